// ==== hdl/settle_timer.sv ====
// down counter that times the oscillation settle wait
// assumes start and abort come from registers of the sequencer
`default_nettype none
module settle_timer
	import standby_reset_pkg::*;
#(
	parameter int W = SETTLE_W
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic         clkEn,
	// control
	input  wire logic         start,
	input  wire logic         abort,
	input  wire logic [W-1:0] loadCount,
	// status
	output logic              done
);

	typedef struct packed {
		logic         busy;
		logic [W-1:0] count;
		logic         done;
	} timer_s;

	localparam timer_s TIMER_RESET = '{busy: 1'b0, count: '0, done: 1'b0};

	timer_s timer_reg;
	timer_s timer_next;

	always_comb begin
		timer_next = timer_reg;
		timer_next.done = 1'b0;
		// abort wins so a stale count never ends a later wait early
		if (abort) begin
			timer_next.busy = 1'b0;
		end else if (start) begin
			timer_next.busy = 1'b1;
			timer_next.count = loadCount - W'(1);
		end else if (timer_reg.busy) begin
			if (timer_reg.count == '0) begin
				timer_next.busy = 1'b0;
				timer_next.done = 1'b1;
			end else begin
				timer_next.count = timer_reg.count - W'(1);
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			timer_reg <= TIMER_RESET;
		end else if (clkEn) begin
			timer_reg <= timer_next;
		end
	end

	assign done = timer_reg.done;

endmodule
`default_nettype wire

// ==== hdl/standby_release_and_reset_control.sv ====
// standby release and system reset sequencer of an 8-bit controller
// assumes all inputs synchronous to ref_clk, the main system clock
//
// Notes on behaviour
// - unmasked interrupt ends halt; service if acceptance enabled, else resume
// - halt wake takes 8 clocks before service, 2 before plain resume
// - non-maskable request ends halt and always starts service
// - reset while halted behaves exactly like a normal reset
// - masked holds halt; high priority needs enable; low needs enable and isp
// - stop entered by stop instruction only while on main clock; oscillator stops
// - pending unmasked request at stop falls back to halt; service or resume after settle wait
// - in stop only external-count timers, external-clock serial and pins run
// - unmasked interrupt releases stop; after settle, service or resume
// - reset in stop clears it, reset processing after settle time
// - stop release uses halt selection; masked stays stopped; nmi does not release
// - pin low or watchdog overflow both reset, vector at 0000H/0001H
// - pins high impedance during reset and following settle wait
// - after reset pin rises wait 2^17 main clocks before execution
// - watchdog reset clears itself then waits 2^17 main clocks
// - during reset main oscillator stopped, subsystem oscillator running
// - reset out of stop keeps retained state while pins go high impedance
// - settle select codes 0,1,2,7,4 give 2^12,14,15,16,17 clocks; others prohibited
// - reset sets settle select to 04H, the longest wait
// - halt gates only cpu clock; oscillator runs so no settle wait
`default_nettype none
module standby_release_and_reset_control
	import standby_reset_pkg::*;
#(
	parameter int NUM_SOURCES        = NUM_SOURCES_DEF,
	parameter int SETTLE_2P14_CYCLES = SETTLE_2P14_DEF,
	parameter int SETTLE_2P15_CYCLES = SETTLE_2P15_DEF,
	parameter int SETTLE_2P16_CYCLES = SETTLE_2P16_DEF,
	parameter int SETTLE_2P17_CYCLES = SETTLE_2P17_DEF,
	parameter int RESET_SETTLE_CYCLES = RESET_SETTLE_DEF
) (
	// clock, reset, clock enable
	input  wire logic                   ref_clk,
	input  wire logic                   reset_n,
	input  wire logic                   clkEn,
	// reset sources
	input  wire logic                   extResetPin_n,
	input  wire logic                   watchdogOverflow,
	// cpu instruction strobes
	input  wire logic                   haltExec,
	input  wire logic                   stopExec,
	input  wire logic                   mainClockSelected,
	// interrupt controller flags
	input  wire logic [NUM_SOURCES-1:0] intRequestFlags,
	input  wire logic [NUM_SOURCES-1:0] interruptMaskFlags,
	input  wire logic [NUM_SOURCES-1:0] prioritySelectFlags,
	input  wire logic                   interruptAcceptEnable,
	input  wire logic                   inServicePriority,
	input  wire logic                   nmiRequest,
	// settle select write
	input  wire logic                   oscSettleWrite,
	input  wire logic [2:0]             oscSettleWdata,
	// clock control
	output logic                        cpuClockEnable,
	output logic                        mainOscEnable,
	output logic                        subOscEnable,
	output logic                        crystalOutputPullup,
	// cpu sequencing
	output logic                        cpuResetActive,
	output logic                        resetVectorFetch,
	output logic                        resumeNext,
	output logic                        vectorService,
	// status
	output logic                        haltActive,
	output logic                        stopActive,
	output logic                        pinsHighZ,
	output logic                        standbyRetain,
	output logic [2:0]                  oscSettleSelect,
	output logic                        settleSelectRejected,
	// peripheral gating during stop
	output logic                        timerExtCountOnly,
	output logic                        serialExtClockOnly,
	output logic                        extInterruptPinsActive
);

	typedef struct packed {
		mode_e                 mode;
		logic [WAKE_CNT_W-1:0] wakeCnt;
		logic                  serviceNext;
		logic                  settleStart;
		logic [2:0]            settleSel;
		logic                  cpuClockEnable;
		logic                  mainOscEnable;
		logic                  subOscEnable;
		logic                  crystalPullup;
		logic                  cpuResetActive;
		logic                  resetVectorPulse;
		logic                  resumePulse;
		logic                  servicePulse;
		logic                  haltActive;
		logic                  stopActive;
		logic                  pinsHighZ;
		logic                  standbyRetain;
		logic                  selectRejected;
		logic                  timerExtOnly;
		logic                  serialExtOnly;
		logic                  extIntActive;
	} state_s;

	localparam state_s STATE_RESET = '{
		mode:             ST_RESET_HOLD,
		wakeCnt:          '0,
		serviceNext:      1'b0,
		settleStart:      1'b0,
		settleSel:        SETTLE_SEL_RESET,
		cpuClockEnable:   1'b0,
		mainOscEnable:    1'b0,
		subOscEnable:     1'b1,
		crystalPullup:    1'b0,
		cpuResetActive:   1'b1,
		resetVectorPulse: 1'b0,
		resumePulse:      1'b0,
		servicePulse:     1'b0,
		haltActive:       1'b0,
		stopActive:       1'b0,
		pinsHighZ:        1'b1,
		standbyRetain:    1'b0,
		selectRejected:   1'b0,
		timerExtOnly:     1'b0,
		serialExtOnly:    1'b0,
		extIntActive:     1'b1
	};

	state_s              state_reg;
	state_s              state_next;
	logic                settleDone;
	logic                sysResetReq;
	logic                settleAbort;
	logic [SETTLE_W-1:0] settleLoad;
	wake_e               wakeReq;

	// maskable wake decision shared by halt and stop release
	function automatic wake_e wakeDecision(
		input logic [NUM_SOURCES-1:0] req,
		input logic [NUM_SOURCES-1:0] mask,
		input logic [NUM_SOURCES-1:0] prio,
		input logic                   ie,
		input logic                   in_service_priority
	);
		logic [NUM_SOURCES-1:0] pend;
		pend = req & ~mask;
		if (pend == '0) begin
			wakeDecision = WAKE_NONE;
		end else if (((|(pend & ~prio)) && ie) || ((|(pend & prio)) && ie && in_service_priority)) begin
			wakeDecision = WAKE_SERVICE;
		end else begin
			wakeDecision = WAKE_RESUME;
		end
	endfunction

	function automatic logic settleCodeLegal(input logic [2:0] sel);
		settleCodeLegal = (sel == SETTLE_SEL_2P12) || (sel == SETTLE_SEL_2P14) ||
			(sel == SETTLE_SEL_2P15) || (sel == SETTLE_SEL_2P16) ||
			(sel == SETTLE_SEL_2P17);
	endfunction

	function automatic logic [SETTLE_W-1:0] settleCycles(input logic [2:0] sel);
		if (sel == SETTLE_SEL_2P12) begin
			settleCycles = SETTLE_W'(SETTLE_2P12_CYCLES);
		end else if (sel == SETTLE_SEL_2P14) begin
			settleCycles = SETTLE_W'(SETTLE_2P14_CYCLES);
		end else if (sel == SETTLE_SEL_2P15) begin
			settleCycles = SETTLE_W'(SETTLE_2P15_CYCLES);
		end else if (sel == SETTLE_SEL_2P16) begin
			settleCycles = SETTLE_W'(SETTLE_2P16_CYCLES);
		end else begin
			settleCycles = SETTLE_W'(SETTLE_2P17_CYCLES);
		end
	endfunction

	assign sysResetReq = !extResetPin_n || watchdogOverflow;
	assign wakeReq = wakeDecision(intRequestFlags, interruptMaskFlags, prioritySelectFlags,
		interruptAcceptEnable, inServicePriority);
	assign settleAbort = (state_reg.mode != ST_SETTLE) && (state_reg.mode != ST_RESET_SETTLE);
	// reset release always waits the longest time, whatever the select holds
	assign settleLoad = (state_reg.mode == ST_RESET_SETTLE) ?
		SETTLE_W'(RESET_SETTLE_CYCLES) : settleCycles(state_reg.settleSel);

	always_comb begin
		state_next = state_reg;
		state_next.resetVectorPulse = 1'b0;
		state_next.resumePulse = 1'b0;
		state_next.servicePulse = 1'b0;
		state_next.settleStart = 1'b0;
		state_next.selectRejected = 1'b0;
		// prohibited codes are dropped so the wait is always one of the five
		if (oscSettleWrite && state_reg.mode == ST_RUN) begin
			if (settleCodeLegal(oscSettleWdata)) begin
				state_next.settleSel = oscSettleWdata;
			end else begin
				state_next.selectRejected = 1'b1;
			end
		end
		if (sysResetReq) begin
			// a watchdog pulse passes through here for one cycle and clears itself
			if (state_reg.mode == ST_STOP) begin
				state_next.standbyRetain = 1'b1;
			end
			state_next.mode = ST_RESET_HOLD;
			state_next.settleSel = SETTLE_SEL_RESET;
			state_next.cpuClockEnable = 1'b0;
			state_next.mainOscEnable = 1'b0;
			state_next.subOscEnable = 1'b1;
			state_next.crystalPullup = 1'b0;
			state_next.cpuResetActive = 1'b1;
			state_next.pinsHighZ = 1'b1;
			state_next.haltActive = 1'b0;
			state_next.stopActive = 1'b0;
			state_next.timerExtOnly = 1'b0;
			state_next.serialExtOnly = 1'b0;
			state_next.serviceNext = 1'b0;
		end else begin
			case (state_reg.mode)
				ST_RESET_HOLD: begin
					state_next.mode = ST_RESET_SETTLE;
					state_next.mainOscEnable = 1'b1;
					state_next.settleStart = 1'b1;
				end
				ST_RESET_SETTLE: begin
					if (settleDone) begin
						state_next.mode = ST_RUN;
						state_next.cpuClockEnable = 1'b1;
						state_next.cpuResetActive = 1'b0;
						state_next.pinsHighZ = 1'b0;
						state_next.standbyRetain = 1'b0;
						state_next.resetVectorPulse = 1'b1;
					end
				end
				ST_RUN: begin
					if (haltExec) begin
						// oscillator left running, hence no settle wait on wake
						state_next.mode = ST_HALT;
						state_next.cpuClockEnable = 1'b0;
						state_next.haltActive = 1'b1;
					end else if (stopExec && mainClockSelected) begin
						if (wakeReq != WAKE_NONE) begin
							state_next.mode = ST_SETTLE;
							state_next.cpuClockEnable = 1'b0;
							state_next.haltActive = 1'b1;
							state_next.serviceNext = (wakeReq == WAKE_SERVICE);
							state_next.settleStart = 1'b1;
						end else begin
							state_next.mode = ST_STOP;
							state_next.cpuClockEnable = 1'b0;
							state_next.mainOscEnable = 1'b0;
							state_next.crystalPullup = 1'b1;
							state_next.stopActive = 1'b1;
							state_next.timerExtOnly = 1'b1;
							state_next.serialExtOnly = 1'b1;
						end
					end
				end
				ST_HALT: begin
					if (nmiRequest) begin
						state_next.mode = ST_WAKE_DELAY;
						state_next.serviceNext = 1'b1;
						state_next.wakeCnt = WAKE_CNT_W'(WAKE_VECTOR_CLOCKS - 1);
					end else if (wakeReq == WAKE_SERVICE) begin
						state_next.mode = ST_WAKE_DELAY;
						state_next.serviceNext = 1'b1;
						state_next.wakeCnt = WAKE_CNT_W'(WAKE_VECTOR_CLOCKS - 1);
					end else if (wakeReq == WAKE_RESUME) begin
						state_next.mode = ST_WAKE_DELAY;
						state_next.serviceNext = 1'b0;
						state_next.wakeCnt = WAKE_CNT_W'(WAKE_RESUME_CLOCKS - 1);
					end
				end
				ST_WAKE_DELAY: begin
					if (state_reg.wakeCnt == '0) begin
						state_next.mode = ST_RUN;
						state_next.cpuClockEnable = 1'b1;
						state_next.haltActive = 1'b0;
						state_next.servicePulse = state_reg.serviceNext;
						state_next.resumePulse = !state_reg.serviceNext;
					end else begin
						state_next.wakeCnt = state_reg.wakeCnt - WAKE_CNT_W'(1);
					end
				end
				ST_STOP: begin
					// the non-maskable request is not looked at here
					if (wakeReq != WAKE_NONE) begin
						state_next.mode = ST_SETTLE;
						state_next.serviceNext = (wakeReq == WAKE_SERVICE);
						state_next.mainOscEnable = 1'b1;
						state_next.crystalPullup = 1'b0;
						state_next.stopActive = 1'b0;
						state_next.haltActive = 1'b1;
						state_next.timerExtOnly = 1'b0;
						state_next.serialExtOnly = 1'b0;
						state_next.settleStart = 1'b1;
					end
				end
				ST_SETTLE: begin
					if (settleDone) begin
						state_next.mode = ST_RUN;
						state_next.cpuClockEnable = 1'b1;
						state_next.haltActive = 1'b0;
						state_next.servicePulse = state_reg.serviceNext;
						state_next.resumePulse = !state_reg.serviceNext;
					end
				end
				default: begin
					state_next.mode = ST_RESET_HOLD;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= STATE_RESET;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	settle_timer #(
		.W(SETTLE_W)
	) u_settle_timer (
		.ref_clk   (ref_clk),
		.reset_n   (reset_n),
		.clkEn     (clkEn),
		.start     (state_reg.settleStart),
		.abort     (settleAbort),
		.loadCount (settleLoad),
		.done      (settleDone)
	);

	assign cpuClockEnable = state_reg.cpuClockEnable;
	assign mainOscEnable = state_reg.mainOscEnable;
	assign subOscEnable = state_reg.subOscEnable;
	assign crystalOutputPullup = state_reg.crystalPullup;
	assign cpuResetActive = state_reg.cpuResetActive;
	assign resetVectorFetch = state_reg.resetVectorPulse;
	assign resumeNext = state_reg.resumePulse;
	assign vectorService = state_reg.servicePulse;
	assign haltActive = state_reg.haltActive;
	assign stopActive = state_reg.stopActive;
	assign pinsHighZ = state_reg.pinsHighZ;
	assign standbyRetain = state_reg.standbyRetain;
	assign oscSettleSelect = state_reg.settleSel;
	assign settleSelectRejected = state_reg.selectRejected;
	assign timerExtCountOnly = state_reg.timerExtOnly;
	assign serialExtClockOnly = state_reg.serialExtOnly;
	assign extInterruptPinsActive = state_reg.extIntActive;

	// helper: clock-enabled cycles spent in the reset settle wait
	logic [SETTLE_W:0] resetWaitCount;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			resetWaitCount <= '0;
		end else if (clkEn) begin
			if (state_reg.mode != ST_RESET_SETTLE) begin
				resetWaitCount <= '0;
			end else begin
				resetWaitCount <= resetWaitCount + (SETTLE_W + 1)'(1);
			end
		end
	end

	property p_pins_hiz;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_RESET_HOLD || state_reg.mode == ST_RESET_SETTLE) |->
			pinsHighZ && cpuResetActive;
	endproperty
	a_pins_hiz: assert property (p_pins_hiz) else $error("pins not high-z in reset");

	property p_reset_osc;
		@(posedge ref_clk) disable iff (!reset_n)
		state_reg.mode == ST_RESET_HOLD |-> !mainOscEnable && subOscEnable;
	endproperty
	a_reset_osc: assert property (p_reset_osc) else $error("oscillators wrong in reset");

	property p_reset_wait;
		@(posedge ref_clk) disable iff (!reset_n)
		$rose(resetVectorFetch) |-> $past(resetWaitCount) >= (SETTLE_W + 1)'(RESET_SETTLE_CYCLES);
	endproperty
	a_reset_wait: assert property (p_reset_wait) else $error("reset settle too short");

	property p_reset_sel;
		@(posedge ref_clk) disable iff (!reset_n)
		(sysResetReq && clkEn) |=> oscSettleSelect == SETTLE_SEL_RESET && cpuResetActive &&
			state_reg.mode == ST_RESET_HOLD;
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("reset did not load select");

	property p_nmi_halt;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_HALT && nmiRequest && !sysResetReq && clkEn) |=>
			state_reg.serviceNext && state_reg.wakeCnt == WAKE_CNT_W'(WAKE_VECTOR_CLOCKS - 1);
	endproperty
	a_nmi_halt: assert property (p_nmi_halt) else $error("nmi did not start service");

	property p_halt_masked;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_HALT && wakeReq == WAKE_NONE && !nmiRequest && !sysResetReq) |=>
			state_reg.mode == ST_HALT && !cpuClockEnable;
	endproperty
	a_halt_masked: assert property (p_halt_masked) else $error("masked source left halt");

	property p_resume_fast;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_HALT && wakeReq == WAKE_RESUME && !nmiRequest && !sysResetReq &&
			clkEn) ##1 clkEn && !sysResetReq ##1 clkEn && !sysResetReq |=>
			resumeNext && cpuClockEnable && !vectorService;
	endproperty
	a_resume_fast: assert property (p_resume_fast) else $error("resume latency wrong");

	property p_stop_nmi;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_STOP && wakeReq == WAKE_NONE && !sysResetReq) |=>
			state_reg.mode == ST_STOP && stopActive;
	endproperty
	a_stop_nmi: assert property (p_stop_nmi) else $error("stop left without release");

	property p_stop_pending;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_RUN && stopExec && !haltExec && mainClockSelected &&
			wakeReq != WAKE_NONE && !sysResetReq && clkEn) |=>
			state_reg.mode == ST_SETTLE && haltActive && !stopActive;
	endproperty
	a_stop_pending: assert property (p_stop_pending) else $error("pending stop not halted");

	property p_stop_clock;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_RUN && stopExec && !haltExec && !mainClockSelected && !sysResetReq)
			|=> !stopActive;
	endproperty
	a_stop_clock: assert property (p_stop_clock) else $error("stop entered off main clock");

	property p_stop_gating;
		@(posedge ref_clk) disable iff (!reset_n)
		stopActive |-> timerExtCountOnly && serialExtClockOnly && extInterruptPinsActive &&
			!mainOscEnable && !cpuClockEnable;
	endproperty
	a_stop_gating: assert property (p_stop_gating) else $error("stop gating wrong");

	property p_settle_wait;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_reg.mode == ST_SETTLE && !settleDone && !sysResetReq) |=> !cpuClockEnable;
	endproperty
	a_settle_wait: assert property (p_settle_wait) else $error("cpu clock before settle");

endmodule
`default_nettype wire

// ==== hdl/standby_reset_pkg.sv ====
// package of constants and types for the standby release and reset sequencer
// assumes one main clock; all counts are in main-clock periods
`default_nettype none
package standby_reset_pkg;

	// interrupt sources seen by the wake logic
	localparam int NUM_SOURCES_DEF = 8;

	// oscillation settle select codes, reset value selects the longest wait
	localparam logic [2:0] SETTLE_SEL_2P12  = 3'h0;
	localparam logic [2:0] SETTLE_SEL_2P14  = 3'h1;
	localparam logic [2:0] SETTLE_SEL_2P15  = 3'h2;
	localparam logic [2:0] SETTLE_SEL_2P16  = 3'h7;
	localparam logic [2:0] SETTLE_SEL_2P17  = 3'h4;
	localparam logic [2:0] SETTLE_SEL_RESET = 3'h4;

	// settle waits in main-clock periods
	localparam int SETTLE_W            = 18;
	localparam int SETTLE_2P12_CYCLES  = 4096;
	localparam int SETTLE_2P14_DEF     = 16384;
	localparam int SETTLE_2P15_DEF     = 32768;
	localparam int SETTLE_2P16_DEF     = 65536;
	localparam int SETTLE_2P17_DEF     = 131072;
	localparam int RESET_SETTLE_DEF    = 131072;

	// halt wake latency in clocks (documented ranges 8..9 and 2..3)
	localparam int WAKE_VECTOR_CLOCKS  = 8;
	localparam int WAKE_RESUME_CLOCKS  = 2;
	localparam int WAKE_CNT_W          = 4;

	// reset vector is read from these two byte addresses
	localparam logic [15:0] RESET_VECTOR_LOW  = 16'h0000;
	localparam logic [15:0] RESET_VECTOR_HIGH = 16'h0001;

	typedef enum logic [2:0] {
		ST_RESET_HOLD,
		ST_RESET_SETTLE,
		ST_RUN,
		ST_HALT,
		ST_WAKE_DELAY,
		ST_STOP,
		ST_SETTLE
	} mode_e;

	typedef enum logic [1:0] {
		WAKE_NONE,
		WAKE_RESUME,
		WAKE_SERVICE
	} wake_e;

endpackage
`default_nettype wire

// ==== verif/reset_pin_model.sv ====
// partner model: the board-side driver of the external reset pin
// assumes ref_clk at 25 MHz, so 250 periods make the minimum low time
`default_nettype none
module reset_pin_model (
	// clock
	input  wire logic ref_clk,
	// reset pin
	output logic      extResetPin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial extResetPin_n = 1'b1;
	// a shorter pulse would be outside what the board may do
	task automatic pulse();
		@(posedge ref_clk);
		#1 extResetPin_n = 1'b0;
		repeat (250) @(posedge ref_clk);
		#1 extResetPin_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// ==== verif/tb_standby_release_and_reset_control.sv ====
// self-checking bench for the standby release and reset sequencer
// assumes settle counts shortened by parameters; code 7 selects 24 cycles
`default_nettype none
module tb_standby_release_and_reset_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, reset_n, clkEn, extResetPin_n, watchdogOverflow, haltExec, stopExec;
	logic mainClockSelected, nmiRequest, interruptAcceptEnable, inServicePriority, oscSettleWrite;
	logic [7:0] intRequestFlags, interruptMaskFlags, prioritySelectFlags;
	logic [2:0] oscSettleWdata, oscSettleSelect;
	logic cpuClockEnable, mainOscEnable, subOscEnable, crystalOutputPullup, cpuResetActive;
	logic resetVectorFetch, resumeNext, vectorService, haltActive, stopActive, pinsHighZ;
	logic standbyRetain, settleSelectRejected, timerExtCountOnly, serialExtClockOnly;
	logic extInterruptPinsActive;
	int nMismatch, samplesChecked, k;
	standby_release_and_reset_control #(.RESET_SETTLE_CYCLES(16), .SETTLE_2P14_CYCLES(16),
		.SETTLE_2P15_CYCLES(20), .SETTLE_2P16_CYCLES(24), .SETTLE_2P17_CYCLES(32)) DUT (
		.ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
		.extResetPin_n(extResetPin_n), .watchdogOverflow(watchdogOverflow),
		.haltExec(haltExec), .stopExec(stopExec), .mainClockSelected(mainClockSelected),
		.intRequestFlags(intRequestFlags), .interruptMaskFlags(interruptMaskFlags),
		.prioritySelectFlags(prioritySelectFlags),
		.interruptAcceptEnable(interruptAcceptEnable),
		.inServicePriority(inServicePriority), .nmiRequest(nmiRequest),
		.oscSettleWrite(oscSettleWrite), .oscSettleWdata(oscSettleWdata),
		.cpuClockEnable(cpuClockEnable), .mainOscEnable(mainOscEnable),
		.subOscEnable(subOscEnable), .crystalOutputPullup(crystalOutputPullup),
		.cpuResetActive(cpuResetActive), .resetVectorFetch(resetVectorFetch),
		.resumeNext(resumeNext), .vectorService(vectorService),
		.haltActive(haltActive), .stopActive(stopActive), .pinsHighZ(pinsHighZ),
		.standbyRetain(standbyRetain), .oscSettleSelect(oscSettleSelect),
		.settleSelectRejected(settleSelectRejected), .timerExtCountOnly(timerExtCountOnly),
		.serialExtClockOnly(serialExtClockOnly),
		.extInterruptPinsActive(extInterruptPinsActive));
	reset_pin_model pin (.ref_clk(ref_clk), .extResetPin_n(extResetPin_n));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// bounded wait for any completion pulse; 200 means none came
	task automatic waitPulse(output int n);
		n = 0;
		do begin
			tick();
			n++;
		end while (n < 200 && !(resumeNext === 1'b1 || vectorService === 1'b1
			|| resetVectorFetch === 1'b1));
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samplesChecked, nMismatch);
		if (nMismatch == 0 && samplesChecked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic resetSettle();
		chk({pinsHighZ, cpuResetActive, mainOscEnable, subOscEnable}, 16'hD);
		waitPulse(k);
		chk({resetVectorFetch, pinsHighZ, cpuResetActive, k >= 16 && k <= 22}, 16'h9);
		chk(oscSettleSelect, 16'h4);
	endtask
	task automatic wake(input logic st, m, p, e, s, n, input int lo, hi, input logic [1:0] ex);
		interruptMaskFlags = {7'h7F, m};
		prioritySelectFlags = {7'h00, p};
		interruptAcceptEnable = e;
		inServicePriority = s;
		if (st) stopExec = 1'b1;
		else haltExec = 1'b1;
		tick();
		haltExec = 1'b0;
		stopExec = 1'b0;
		chk({haltActive, stopActive, mainOscEnable, cpuClockEnable}, st ? 16'h4 : 16'hA);
		chk({crystalOutputPullup, timerExtCountOnly, serialExtClockOnly, extInterruptPinsActive},
			st ? 16'hF : 16'h1);
		nmiRequest = n;
		intRequestFlags = 8'h01;
		waitPulse(k);
		chk({vectorService, resumeNext}, ex);
		if (k < lo || k > hi) chk(k[15:0], lo[15:0]);
		nmiRequest = 1'b0;
		if (ex == 2'b00) begin
			chk({haltActive, stopActive}, {!st, st});
			interruptMaskFlags = 8'h00;
			waitPulse(k);
		end
		intRequestFlags = 8'h00;
		tick();
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		nMismatch++;
		finish_test();
	end
	initial begin
		{reset_n, clkEn, watchdogOverflow, haltExec, stopExec, nmiRequest} = 6'h10;
		{interruptAcceptEnable, inServicePriority, oscSettleWrite, oscSettleWdata} = 6'h00;
		{intRequestFlags, interruptMaskFlags, prioritySelectFlags} = 24'h00FF00;
		mainClockSelected = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk(oscSettleSelect, 16'h4);
		reset_n = 1'b1;
		resetSettle();
		oscSettleWrite = 1'b1;
		oscSettleWdata = 3'h7;
		tick();
		oscSettleWdata = 3'h3;
		tick();
		oscSettleWrite = 1'b0;
		chk({settleSelectRejected, oscSettleSelect}, 16'hF);
		wake(0, 0, 0, 0, 0, 0, 2, 4, 2'b01);
		wake(0, 0, 0, 1, 0, 0, 8, 10, 2'b10);
		wake(0, 0, 1, 0, 1, 0, 2, 4, 2'b01);
		wake(0, 0, 1, 1, 0, 0, 2, 4, 2'b01);
		wake(0, 0, 1, 1, 1, 0, 8, 10, 2'b10);
		wake(0, 1, 0, 1, 1, 0, 0, 200, 2'b00);
		wake(0, 1, 0, 0, 0, 1, 8, 10, 2'b10);
		wake(1, 0, 0, 1, 0, 0, 24, 30, 2'b10);
		wake(1, 0, 0, 0, 0, 0, 24, 30, 2'b01);
		wake(1, 0, 1, 1, 0, 0, 24, 30, 2'b01);
		wake(1, 0, 1, 1, 1, 0, 24, 30, 2'b10);
		wake(1, 1, 0, 1, 0, 1, 0, 200, 2'b00);
		mainClockSelected = 1'b0;
		stopExec = 1'b1;
		tick();
		stopExec = 1'b0;
		chk(stopActive, 16'h0);
		mainClockSelected = 1'b1;
		oscSettleWrite = 1'b1;
		oscSettleWdata = 3'h2;
		tick();
		oscSettleWrite = 1'b0;
		chk(oscSettleSelect, 16'h2);
		intRequestFlags = 8'h01;
		interruptMaskFlags = 8'hFE;
		stopExec = 1'b1;
		tick();
		stopExec = 1'b0;
		tick();
		chk({haltActive, stopActive}, 16'h2);
		waitPulse(k);
		chk({k >= 20 && k <= 23, vectorService}, 16'h3);
		{intRequestFlags, interruptMaskFlags} = 16'h00FF;
		tick();
		stopExec = 1'b1;
		tick();
		stopExec = 1'b0;
		pin.pulse();
		chk(standbyRetain, 16'h1);
		resetSettle();
		haltExec = 1'b1;
		tick();
		haltExec = 1'b0;
		chk(haltActive, 16'h1);
		watchdogOverflow = 1'b1;
		tick();
		watchdogOverflow = 1'b0;
		chk(haltActive, 16'h0);
		resetSettle();
		finish_test();
	end
endmodule
`default_nettype wire
